// ==== common/sdc_map.svh ====
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
// register word addresses
`define SDC_A_PREC 8'h00
`define SDC_A_GSRC 8'h01
`define SDC_A_GDST 8'h02
`define SDC_A_GCNT 8'h03
`define SDC_A_GFRM 8'h04
`define SDC_A_EST0 8'h05
`define SDC_A_EST1 8'h06
`define SDC_A_FST0 8'h07
`define SDC_A_FST1 8'h08
`define SDC_A_STAT 8'h09
// channel page: addr[7:6] = page, addr[5:3] = channel, addr[2:0] = reg
`define SDC_CH_PAGE 2'h1
`define SDC_R_SRC 3'h0
`define SDC_R_DST 3'h1
`define SDC_R_CTR 3'h2
`define SDC_R_SFC 3'h3
`define SDC_R_MCR 3'h4
// field positions
`define SDC_PR_EN 0
`define SDC_PR_HI 8
`define SDC_PR_SEL 14
`define SDC_MCR_AUTO 15
`define SDC_MCR_IEN 14
`define SDC_MCR_IEVT 13
`define SDC_MCR_AUTOBUF 12
`define SDC_MCR_DBL 11
`define SDC_MCR_SM 6
`define SDC_MCR_SIX 5
`define SDC_MCR_DM 3
`define SDC_MCR_DIX 2
`define SDC_SFC_SYN 12
// reset values
`define SDC_RST16 16'h0000
`define SDC_RST8 8'h00
// sync event codes
`define SDC_SY_NONE 4'h0
`define SDC_SY_S0RX 4'h1
`define SDC_SY_S0TX 4'h2
`define SDC_SY_S1RX 4'h5
`define SDC_SY_S1TX 4'h6
`define SDC_SY_TM0 4'hD
`define SDC_SY_EX3 4'hE
`define SDC_SY_TM1 4'hF
// shared line routing codes
`define SDC_SEL_PERI 2'h0
`define SDC_SEL_23 2'h1
`define SDC_SEL_ALL 2'h2
`endif

// ==== common/sdc_pkg.sv ====
`default_nettype none
package sdc_pkg;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RD = 2'b01,
    S_CAP = 2'b10,
    S_WR = 2'b11
  } sdc_state_t;
  typedef enum logic [1:0] {
    AM_HOLD = 2'b00,
    AM_INC = 2'b01,
    AM_DEC = 2'b10,
    AM_IDX = 2'b11
  } sdc_amode_t;
endpackage : sdc_pkg
`default_nettype wire

// ==== rtl/sdc_dma.sv ====
// Overview of operation
// - each channel high or low priority; equal level served round robin
// - source and destination stepped apart: hold, +1, -1 or +index
// - auto reload brings source, destination, count from global reloads
// - globals may change mid block; the active channel values are used
// - global reload values stay untouched and serve every later block
// - 8-bit frame counter decremented when a frame's last write ends
// - frame count zero means one frame; all ones is the largest count
// - auto reload refills the frame counter from its global reload
// - 16-bit element counter drops per element; all ones gives 65536
// - auto reload refills the element counter from global count reload
// - double word: two 16-bit moves per element, addresses step each
// - index select bits choose element and frame step registers
// - element step added on every transfer but a frame's last
// - frame step added on a frame's last transfer, any frame count
// - interrupt enable clear silences the channel whatever the mode
// - auto-buffer: full or half+full; multi-frame: block or frame+block
// - 4-bit sync field picks the trigger event; others reserved
// - every channel raises its own interrupt; 0 to 3 share lines
// - routing field maps shared lines 6, 7, 10, 11
// - transfer addresses go out unchanged by memory config bits
// - dma access wins over a concurrent cpu access
// - six independent channel contexts
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "sdc_map.svh"
`default_nettype none
module sdc_dma (
  input wire logic ref_clk, // 250 MHz
  input wire logic srst, // sync reset, high
  input wire logic [7:0] reg_addr, // register word address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, next cycle
  output logic mem_req, // memory access request
  output logic mem_we, // 1 write, 0 read
  output logic [15:0] mem_addr, // memory word address
  output logic [15:0] mem_wdata, // memory write data
  input wire logic [15:0] mem_rdata, // read data, cycle after req
  input wire logic cpu_req, // cpu wants the memory
  output logic cpu_gnt, // cpu may use the memory
  input wire logic s0_rx_evt, // serial 0 receive pulse
  input wire logic s0_tx_evt, // serial 0 transmit pulse
  input wire logic s1_rx_evt, // serial 1 receive pulse
  input wire logic s1_tx_evt, // serial 1 transmit pulse
  input wire logic tmr0_evt, // timer 0 pulse
  input wire logic ext3_pin, // external interrupt 3 pin
  input wire logic tmr1_evt, // timer 1 pulse
  input wire logic timer1_irq, // timer 1 interrupt
  input wire logic serial1_receive_irq, // serial 1 rx interrupt
  input wire logic serial1_transmit_irq, // serial 1 tx interrupt
  output logic [3:0] irq_line, // cpu lines 6, 7, 10, 11
  output logic irq_ch4, // channel 4 interrupt
  output logic irq_ch5 // channel 5 interrupt
);
  logic [15:0] prec, gsrc, gdst, gcnt;
  logic [7:0] gfrm;
  logic [15:0] estep [2];
  logic [15:0] fstep [2];
  logic [15:0] src [6];
  logic [15:0] dst [6];
  logic [15:0] ctr [6];
  logic [15:0] cinit [6];
  logic [15:0] mcr [6];
  logic [3:0] syn [6];
  logic [7:0] frm [6];
  logic [5:0] pend, ch_irq, ready, hi_req, lo_req;
  sdc_pkg::sdc_state_t state;
  logic [2:0] cur, last_hi, last_lo, pick;
  logic half, x3_m, x3_s, x3_d, start, dbl, lastx, elem_done;
  logic frm_end, blk_end, half_pt;
  logic [15:0] evt, mc;
  logic ch_wr;
  logic [2:0] chn;

  // round robin: first requester after the last one served
  function automatic logic [2:0] rr_pick(input logic [5:0] req,
                                         input logic [2:0] last);
    logic [2:0] idx;
    logic [2:0] pk;
    pk = last;
    for (int i = 6; i >= 1; i--) begin
      idx = 3'((int'(last) + i) % 6);
      if (req[idx]) begin
        pk = idx;
      end
    end
    return pk;
  endfunction : rr_pick

  // post-modify one address
  function automatic logic [15:0] step(input logic [15:0] a,
                                       input logic [1:0] m,
                                       input logic [15:0] ix);
    case (sdc_pkg::sdc_amode_t'(m))
      sdc_pkg::AM_HOLD: step = a;
      sdc_pkg::AM_INC: step = a + 16'h0001;
      sdc_pkg::AM_DEC: step = a - 16'h0001;
      default: step = a + ix;
    endcase
  endfunction : step

  // only documented sync codes may ever trigger
  function automatic logic sync_ok(input logic [3:0] s);
    case (s)
      `SDC_SY_NONE, `SDC_SY_S0RX, `SDC_SY_S0TX, `SDC_SY_S1RX,
      `SDC_SY_S1TX, `SDC_SY_TM0, `SDC_SY_EX3, `SDC_SY_TM1: sync_ok = 1'b1;
      default: sync_ok = 1'b0;
    endcase
  endfunction : sync_ok

  // external pin is asynchronous: two flops, then edge on the clean copy
  always_ff @(posedge ref_clk) begin
    x3_m <= ext3_pin;
    x3_s <= x3_m;
    x3_d <= x3_s;
  end

  // event vector indexed by sync code; reserved codes read zero
  assign evt = {tmr1_evt, x3_s & ~x3_d, tmr0_evt, 6'h00, s1_tx_evt,
                s1_rx_evt, 2'h0, s0_tx_evt, s0_rx_evt, 1'b0};

  // channel readiness and two-level arbitration
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      ready[i] = prec[`SDC_PR_EN + i] & sync_ok(syn[i]) &
                 ((syn[i] == `SDC_SY_NONE) | pend[i]);
    end
  end
  assign hi_req = ready & prec[`SDC_PR_HI +: 6];
  assign lo_req = ready & ~prec[`SDC_PR_HI +: 6];
  assign pick = (|hi_req) ? rr_pick(hi_req, last_hi) :
                rr_pick(lo_req, last_lo);
  assign start = (state == sdc_pkg::S_IDLE) && (|ready);

  // per-element decode for the channel in service
  assign mc = mcr[cur];
  assign dbl = mc[`SDC_MCR_DBL];
  assign lastx = (ctr[cur] == 16'h0000) && (!dbl || half);
  assign elem_done = (state == sdc_pkg::S_WR) && (!dbl || half);
  assign frm_end = elem_done && (ctr[cur] == 16'h0000);
  assign blk_end = frm_end && (frm[cur] == 8'h00);
  assign half_pt = elem_done && (ctr[cur] == {1'b0, cinit[cur][15:1]});
  assign ch_wr = reg_wr && (reg_addr[7:6] == `SDC_CH_PAGE) &&
                 (reg_addr[5:3] < 3'h6);
  assign chn = reg_addr[5:3];

  // memory always goes to the engine first; cpu waits its turn
  assign cpu_gnt = cpu_req & ~mem_req;

  // transfer sequencer: read, capture, write; double word loops once
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= sdc_pkg::S_IDLE;
      cur <= 3'h0;
      last_hi <= 3'h5;
      last_lo <= 3'h5;
      half <= 1'b0;
    end else begin
      case (state)
        sdc_pkg::S_IDLE: begin
          if (start) begin
            state <= sdc_pkg::S_RD;
            cur <= pick;
            if (|hi_req) begin
              last_hi <= pick;
            end else begin
              last_lo <= pick;
            end
          end
        end
        sdc_pkg::S_RD: state <= sdc_pkg::S_CAP;
        sdc_pkg::S_CAP: state <= sdc_pkg::S_WR;
        sdc_pkg::S_WR: begin
          if (dbl && !half) begin
            half <= 1'b1;
            state <= sdc_pkg::S_RD;
          end else begin
            half <= 1'b0;
            state <= sdc_pkg::S_IDLE;
          end
        end
        default: state <= sdc_pkg::S_IDLE;
      endcase
    end
  end

  // memory port; addresses go out raw, no memory-config remapping
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= `SDC_RST16;
      mem_wdata <= `SDC_RST16;
    end else begin
      case (state)
        sdc_pkg::S_IDLE: begin
          mem_req <= start;
          mem_we <= 1'b0;
          mem_addr <= src[pick];
        end
        sdc_pkg::S_CAP: begin
          mem_req <= 1'b1;
          mem_we <= 1'b1;
          mem_wdata <= mem_rdata;
          mem_addr <= dst[cur];
        end
        sdc_pkg::S_WR: begin
          mem_req <= dbl && !half;
          mem_we <= 1'b0;
          mem_addr <= src[cur];
        end
        default: begin
          mem_req <= 1'b0;
          mem_we <= 1'b0;
        end
      endcase
    end
  end

  // sync pending flags: a new event beats the clear at element start
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        pend[i] <= (pend[i] & ~(start && pick == 3'(i))) |
                   evt[syn[i]];
      end
    end
  end

  // global registers; hardware only reads the reload set
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prec <= `SDC_RST16;
      gsrc <= `SDC_RST16;
      gdst <= `SDC_RST16;
      gcnt <= `SDC_RST16;
      gfrm <= `SDC_RST8;
      estep <= '{`SDC_RST16, `SDC_RST16};
      fstep <= '{`SDC_RST16, `SDC_RST16};
    end else begin
      if (blk_end && !mc[`SDC_MCR_AUTO]) begin
        prec[`SDC_PR_EN + cur] <= 1'b0;
      end
      if (reg_wr) begin
        case (reg_addr)
          `SDC_A_PREC: prec <= reg_wdata;
          `SDC_A_GSRC: gsrc <= reg_wdata;
          `SDC_A_GDST: gdst <= reg_wdata;
          `SDC_A_GCNT: gcnt <= reg_wdata;
          `SDC_A_GFRM: gfrm <= reg_wdata[7:0];
          `SDC_A_EST0: estep[0] <= reg_wdata;
          `SDC_A_EST1: estep[1] <= reg_wdata;
          `SDC_A_FST0: fstep[0] <= reg_wdata;
          `SDC_A_FST1: fstep[1] <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // six channel contexts: address stepping, counting, auto reload
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < 6; i++) begin
        src[i] <= `SDC_RST16;
        dst[i] <= `SDC_RST16;
        ctr[i] <= `SDC_RST16;
        cinit[i] <= `SDC_RST16;
        mcr[i] <= `SDC_RST16;
        syn[i] <= `SDC_SY_NONE;
        frm[i] <= `SDC_RST8;
      end
    end else begin
      if (state == sdc_pkg::S_CAP) begin
        src[cur] <= step(src[cur], mc[`SDC_MCR_SM +: 2],
                         lastx ? fstep[mc[`SDC_MCR_SIX]] :
                         estep[mc[`SDC_MCR_SIX]]);
      end
      if (state == sdc_pkg::S_WR) begin
        dst[cur] <= step(dst[cur], mc[`SDC_MCR_DM +: 2],
                         lastx ? fstep[mc[`SDC_MCR_DIX]] :
                         estep[mc[`SDC_MCR_DIX]]);
      end
      if (elem_done) begin
        if (ctr[cur] != 16'h0000) begin
          ctr[cur] <= ctr[cur] - 16'h0001;
        end else if (frm[cur] != 8'h00) begin
          frm[cur] <= frm[cur] - 8'h01;
          ctr[cur] <= cinit[cur];
        end else if (mc[`SDC_MCR_AUTO]) begin
          src[cur] <= gsrc;
          dst[cur] <= gdst;
          ctr[cur] <= gcnt;
          cinit[cur] <= gcnt;
          frm[cur] <= gfrm;
        end
      end
      if (ch_wr) begin
        case (reg_addr[2:0])
          `SDC_R_SRC: src[chn] <= reg_wdata;
          `SDC_R_DST: dst[chn] <= reg_wdata;
          `SDC_R_CTR: begin
            ctr[chn] <= reg_wdata;
            cinit[chn] <= reg_wdata;
          end
          `SDC_R_SFC: begin
            syn[chn] <= reg_wdata[`SDC_SFC_SYN +: 4];
            frm[chn] <= reg_wdata[7:0];
          end
          `SDC_R_MCR: mcr[chn] <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // channel interrupt pulses and shared-line routing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ch_irq <= 6'h00;
      irq_line <= 4'h0;
      irq_ch4 <= 1'b0;
      irq_ch5 <= 1'b0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        ch_irq[i] <= (cur == 3'(i)) && mc[`SDC_MCR_IEN] &&
                     (blk_end || (mc[`SDC_MCR_IEVT] &&
                     (mc[`SDC_MCR_AUTOBUF] ? half_pt : frm_end)));
      end
      case (prec[`SDC_PR_SEL +: 2])
        `SDC_SEL_23: irq_line <= {ch_irq[3], ch_irq[2], timer1_irq, 1'b0};
        `SDC_SEL_ALL: irq_line <= ch_irq[3:0];
        default: irq_line <= {serial1_transmit_irq, serial1_receive_irq,
                              timer1_irq, 1'b0};
      endcase
      irq_ch4 <= ch_irq[4];
      irq_ch5 <= ch_irq[5];
    end
  end

  // read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= `SDC_RST16;
    end else if (reg_addr[7:6] == `SDC_CH_PAGE && reg_addr[5:3] < 3'h6) begin
      case (reg_addr[2:0])
        `SDC_R_SRC: reg_rdata <= src[chn];
        `SDC_R_DST: reg_rdata <= dst[chn];
        `SDC_R_CTR: reg_rdata <= ctr[chn];
        `SDC_R_SFC: reg_rdata <= {syn[chn], 4'h0, frm[chn]};
        `SDC_R_MCR: reg_rdata <= mcr[chn];
        default: reg_rdata <= `SDC_RST16;
      endcase
    end else begin
      case (reg_addr)
        `SDC_A_PREC: reg_rdata <= prec;
        `SDC_A_GSRC: reg_rdata <= gsrc;
        `SDC_A_GDST: reg_rdata <= gdst;
        `SDC_A_GCNT: reg_rdata <= gcnt;
        `SDC_A_GFRM: reg_rdata <= {8'h00, gfrm};
        `SDC_A_EST0: reg_rdata <= estep[0];
        `SDC_A_EST1: reg_rdata <= estep[1];
        `SDC_A_FST0: reg_rdata <= fstep[0];
        `SDC_A_FST1: reg_rdata <= fstep[1];
        `SDC_A_STAT: reg_rdata <= {state != sdc_pkg::S_IDLE, cur, 6'h00, pend};
        default: reg_rdata <= `SDC_RST16;
      endcase
    end
  end

  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_dma_wins: assert property ((cpu_req && state == sdc_pkg::S_CAP)
    |=> !cpu_gnt) else $error("cpu granted during dma write");
  a_copy_data: assert property (state == sdc_pkg::S_CAP
    |=> mem_we && mem_req && mem_wdata == $past(mem_rdata))
    else $error("write does not carry the read word");
  a_dbl_pair: assert property ((state == sdc_pkg::S_WR && dbl && !half)
    |=> state == sdc_pkg::S_RD ##2 state == sdc_pkg::S_WR && half)
    else $error("double word lacks second move");
  a_irq_off: assert property ((elem_done && !mc[`SDC_MCR_IEN])
    |=> ch_irq == 6'h00) else $error("interrupt while disabled");
  a_reserved_idle: assert property (start |-> sync_ok(syn[pick]))
    else $error("reserved sync channel started");
  a_frame_dec: assert property ((frm_end && frm[cur] != 8'h00)
    |=> frm[cur] == $past(frm[cur]) - 8'h01 && ctr[cur] == $past(cinit[cur]))
    else $error("frame count not stepped");
  a_elem_dec: assert property ((elem_done && ctr[cur] != 16'h0000)
    |=> ctr[cur] == $past(ctr[cur]) - 16'h0001)
    else $error("element count not stepped");
  a_auto_reload: assert property ((blk_end && mc[`SDC_MCR_AUTO])
    |=> src[cur] == $past(gsrc) && ctr[cur] == $past(gcnt) &&
        frm[cur] == $past(gfrm)) else $error("auto reload missed");
  a_route_def: assert property ($past(prec[`SDC_PR_SEL +: 2]) == 2'h0
    |-> irq_line[1] == $past(timer1_irq) &&
        irq_line[3] == $past(serial1_transmit_irq))
    else $error("default routing wrong");
  a_hi_first: assert property ((start && |hi_req)
    |-> prec[`SDC_PR_HI + pick]) else $error("low channel beat high");

  c_dbl: cover property (state == sdc_pkg::S_WR && half);
  c_reload: cover property (blk_end && mc[`SDC_MCR_AUTO]);
  c_frame_irq: cover property (frm_end && !blk_end ##1 |ch_irq);
  c_route: cover property (irq_line[0]);
endmodule : sdc_dma
`default_nettype wire

// ==== dv/sdc_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// word memory facing the transfer port; it never makes the engine wait
module sdc_mem_model (
  input wire logic ref_clk, // clock
  input wire logic mem_req, // access request
  input wire logic mem_we, // 1 write
  input wire logic [15:0] mem_addr, // word address
  input wire logic [15:0] mem_wdata, // write data
  output logic [15:0] mem_rdata // read data, cycle after request
);
  logic [15:0] mem [logic [15:0]];
  logic [15:0] last_q = 16'h0000;
  // unwritten words hold their address scrambled, so every move shows
  function automatic logic [15:0] peek(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : a ^ 16'hC35A;
  endfunction : peek
  // data stands one cycle, then the inverse so a late capture is caught
  always @(posedge ref_clk) begin
    if (mem_req && !mem_we) begin
      last_q = peek(mem_addr);
      mem_rdata <= last_q;
    end else begin
      mem_rdata <= ~last_q;
    end
    if (mem_req && mem_we) begin
      mem[mem_addr] = mem_wdata;
    end
  end
endmodule : sdc_mem_model
`default_nettype wire

// ==== dv/sdc_dma_tb.sv ====
`timescale 1ns/100ps
`include "sdc_map.svh"
`default_nettype none
module six_channel_dma_transfer_control_tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_req = 1'b0;
  logic [6:0] evt = 7'h00; // s0 rx, s0 tx, s1 rx, s1 tx, tmr0, ext3, tmr1
  logic [2:0] pirq = 3'h0; // timer 1, serial 1 rx, serial 1 tx
  logic [15:0] reg_rdata;
  logic mem_req;
  logic mem_we;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic cpu_gnt;
  logic [3:0] irq_line;
  logic irq_ch4;
  logic irq_ch5;
  int bad_count = 0;
  int tests_run = 0;
  int n4 = 0;
  int n5 = 0;
  int n6 = 0;
  logic [15:0] wq [$];
  logic [15:0] v;
  logic [15:0] mi;
  logic [3:0] sy [7] = '{`SDC_SY_S0RX, `SDC_SY_S0TX, `SDC_SY_S1RX,
    `SDC_SY_S1TX, `SDC_SY_TM0, `SDC_SY_EX3, `SDC_SY_TM1};
  // last entry runs the auto-buffer decode: half point and block end
  logic [4:0] fl [4] = '{5'b01100, 5'b01000, 5'b00100, 5'b01110};
  int np [4] = '{2, 1, 0, 2};
  logic [15:0] xs [4] = '{16'h0300, 16'h0302, 16'h0312, 16'h0314};
  logic [3:0] xl [3] = '{4'hE, 4'h2, 4'h0};
  logic [15:0] xa [10] = '{16'h0500, 16'h0501, 16'h0510, 16'h0511,
    16'h0512, 16'h0513, 16'h0530, 16'h0531, 16'h0532, 16'h0533};

  sdc_dma u_sdc_dma (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .cpu_req(cpu_req), .cpu_gnt(cpu_gnt), .s0_rx_evt(evt[0]),
    .s0_tx_evt(evt[1]), .s1_rx_evt(evt[2]), .s1_tx_evt(evt[3]),
    .tmr0_evt(evt[4]), .ext3_pin(evt[5]), .tmr1_evt(evt[6]),
    .timer1_irq(pirq[0]), .serial1_receive_irq(pirq[1]),
    .serial1_transmit_irq(pirq[2]), .irq_line(irq_line),
    .irq_ch4(irq_ch4), .irq_ch5(irq_ch5)
  );
  sdc_mem_model u_sdc_mem_model (
    .ref_clk(ref_clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );

  // 250 MHz clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] pat(input logic [15:0] a);
    return a ^ 16'hC35A;
  endfunction : pat
  function automatic logic [15:0] md(input logic [4:0] f,
      input logic [1:0] s, input logic si, input logic [1:0] d,
      input logic di);
    return {f, 3'h0, s, si, d, di, 2'h0};
  endfunction : md
  function automatic logic [7:0] ca(input logic [2:0] c,
      input logic [2:0] r);
    return {`SDC_CH_PAGE, c, r};
  endfunction : ca

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // one-cycle strobes, changed only just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rdc(input string nm, input logic [7:0] a,
      input logic [15:0] e);
    rd(a, v);
    chk(nm, v, e);
  endtask : rdc
  task automatic setch(input logic [2:0] c, input logic [15:0] s, d, n, f,
      m);
    wr(ca(c, `SDC_R_SRC), s);
    wr(ca(c, `SDC_R_DST), d);
    wr(ca(c, `SDC_R_CTR), n);
    wr(ca(c, `SDC_R_SFC), f);
    wr(ca(c, `SDC_R_MCR), m);
  endtask : setch
  task automatic pulse(input logic [6:0] m);
    @(posedge ref_clk);
    evt <= m;
    @(posedge ref_clk);
    evt <= 7'h00;
  endtask : pulse
  // polls the enable bit, which hardware clears at block end when auto reload is off
  task automatic wait_off(input int c);
    logic [15:0] x;
    for (int i = 0; i < 300; i++) begin
      rd(`SDC_A_PREC, x);
      if (x[c] === 1'b0) return;
    end
    bad_count++;
    $display("CHECK FAILED done expected 0 seen 1");
    results();
  endtask : wait_off
  task automatic wait_n5(input int t);
    for (int i = 0; i < 400; i++) begin
      if (n5 >= t) return;
      @(posedge ref_clk);
    end
    bad_count++;
    $display("CHECK FAILED pulses expected %0d seen %0d", t, n5);
    results();
  endtask : wait_n5

  // sampled mid-cycle, where registered outputs have settled
  always @(negedge ref_clk) begin
    if (!srst) begin
      n4 = n4 + int'(irq_ch4 === 1'b1);
      n5 = n5 + int'(irq_ch5 === 1'b1);
      n6 = n6 + int'(irq_line[0] === 1'b1);
      if (mem_req === 1'b1 && mem_we === 1'b1) wq.push_back(mem_addr);
      if (cpu_req) chk("cpu_gnt", 16'(cpu_gnt), 16'(!mem_req));
    end
  end

  initial begin
    mi = md(5'h00, 2'h1, 1'b0, 2'h1, 1'b0);
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    rdc("control", `SDC_A_PREC, 16'h0000);
    rdc("status", `SDC_A_STAT, 16'h0000);
    rdc("mode", ca(3'h0, `SDC_R_MCR), 16'h0000);
    wr(8'h3F, 16'hFFFF);
    rdc("unmapped", 8'h3F, 16'h0000);
    rdc("channel6", ca(3'h6, `SDC_R_SRC), 16'h0000);
    $display("test reset done");
    // source steps up, destination held: only the last word remains
    setch(3'h0, 16'h0100, 16'h0200, 16'h0003, 16'h0000,
          md(5'h00, 2'h1, 1'b0, 2'h0, 1'b0));
    cpu_req <= 1'b1;
    wr(`SDC_A_PREC, 16'h0001);
    wait_off(0);
    cpu_req <= 1'b0;
    chk("held", u_sdc_mem_model.peek(16'h0200), pat(16'h0103));
    rdc("src", ca(3'h0, `SDC_R_SRC), 16'h0104);
    rdc("dst", ca(3'h0, `SDC_R_DST), 16'h0200);
    $display("test plain done");
    wr(`SDC_A_EST0, 16'h0007);
    wr(`SDC_A_EST1, 16'h0002);
    wr(`SDC_A_FST0, 16'h0050);
    wr(`SDC_A_FST1, 16'h0010);
    for (int m = 0; m < 4; m++) begin
      n4 = 0;
      setch(3'h4, 16'h0300, 16'h0403, 16'h0001, 16'h0001,
            md(fl[m], 2'h3, 1'b1, 2'h2, 1'b0));
      wr(`SDC_A_PREC, 16'h0010);
      wait_off(4);
      repeat (4) @(posedge ref_clk);
      chk("irqs", 16'(n4), 16'(np[m]));
      rdc("src", ca(3'h4, `SDC_R_SRC), 16'h0324);
      rdc("dst", ca(3'h4, `SDC_R_DST), 16'h03FF);
      rdc("frames", ca(3'h4, `SDC_R_SFC), 16'h0000);
      for (int k = 0; k < 4; k++) begin
        v = u_sdc_mem_model.peek(16'h0403 - 16'(k));
        chk("indexed", v, pat(xs[k]));
      end
    end
    $display("test index done");
    wr(`SDC_A_GSRC, 16'h0510);
    wr(`SDC_A_GDST, 16'h0610);
    wr(`SDC_A_GCNT, 16'h0001);
    setch(3'h5, 16'h0500, 16'h0600, 16'h0000, 16'h0000,
          md(5'b11001, 2'h1, 1'b0, 2'h1, 1'b0));
    wr(`SDC_A_PREC, 16'h0020);
    wait_n5(1);
    // rewritten while the second block runs
    wr(`SDC_A_GSRC, 16'h0530);
    wr(`SDC_A_GDST, 16'h0630);
    wait_n5(3);
    wr(`SDC_A_PREC, 16'h0000);
    repeat (20) @(posedge ref_clk);
    for (int k = 0; k < 10; k++) begin
      v = u_sdc_mem_model.peek(xa[k] + 16'h0100);
      chk("reload", v, pat(xa[k]));
    end
    rdc("global", `SDC_A_GSRC, 16'h0530);
    $display("test reload done");
    for (int k = 0; k < 7; k++) begin
      setch(3'h2, 16'h0800 + 16'(k), 16'h0900 + 16'(k), 16'h0000,
            {sy[k], 12'h000}, mi);
      wr(`SDC_A_PREC, 16'h0004);
      pulse(~(7'h01 << k));
      repeat (20) @(posedge ref_clk);
      rdc("waiting", `SDC_A_PREC, 16'h0004);
      pulse(7'h01 << k);
      wait_off(2);
      v = u_sdc_mem_model.peek(16'h0900 + 16'(k));
      chk("synced", v, pat(16'h0800 + 16'(k)));
    end
    setch(3'h2, 16'h0980, 16'h0990, 16'h0000, 16'h3000, mi);
    wr(`SDC_A_PREC, 16'h0004);
    pulse(7'h7F);
    repeat (30) @(posedge ref_clk);
    rdc("reserved", `SDC_A_PREC, 16'h0004);
    wr(`SDC_A_PREC, 16'h0000);
    chk("idle", u_sdc_mem_model.peek(16'h0990), pat(16'h0990));
    $display("test sync done");
    pirq <= 3'h7;
    for (int k = 0; k < 3; k++) begin
      wr(`SDC_A_PREC, {2'(k), 14'h0000});
      // look mid-cycle, away from the edge that updates the lines
      repeat (3) @(negedge ref_clk);
      chk("lines", {12'h000, irq_line}, {12'h000, xl[k]});
    end
    pirq <= 3'h0;
    setch(3'h0, 16'h0A00, 16'h0B00, 16'h0000, 16'h0000,
          md(5'b01000, 2'h1, 1'b0, 2'h1, 1'b0));
    wr(`SDC_A_PREC, 16'h8001);
    wait_off(0);
    repeat (4) @(posedge ref_clk);
    chk("line6", 16'(n6), 16'h0001);
    $display("test routing done");
    setch(3'h0, 16'h0C00, 16'h0700, 16'h0001, 16'h0000, mi);
    setch(3'h3, 16'h0C30, 16'h0730, 16'h0001, 16'h0000, mi);
    setch(3'h1, 16'h0C10, 16'h0710, 16'h0000, 16'h0000, mi);
    wq.delete();
    cpu_req <= 1'b1;
    wr(`SDC_A_PREC, 16'h020B);
    wait_off(0);
    wait_off(3);
    cpu_req <= 1'b0;
    chk("writes", 16'(wq.size()), 16'h0005);
    chk("first", wq[0], 16'h0710);
    chk("turns", wq[1] ^ wq[2], 16'h0030);
    chk("next", wq[3], wq[1] + 16'h0001);
    chk("last", wq[4], wq[2] + 16'h0001);
    $display("test priority done");
    results();
  end
endmodule : six_channel_dma_transfer_control_tb_top
`default_nettype wire
